// [core/spic_pkg.sv]
// Shared types and constants for the serializer parallel input control block
package spic_pkg;

  localparam int          SYNC_STAGES  = 3;
  localparam int          FILTER_COUNT = 3;
  localparam int          DATA_WIDTH   = 24;
  localparam int          BUF_DEPTH    = 2;
  localparam logic [1:0]  CFG_FILT_OFF = 2'h0;
  localparam logic [1:0]  CFG_FILT_ON  = 2'h1;
  localparam logic [1:0]  CFG_LEGACY_A = 2'h2;
  localparam logic [1:0]  CFG_LEGACY_B = 2'h3;
  localparam logic        RST_SWING    = 1'h0;
  localparam logic        RST_RISING   = 1'h0;
  localparam logic        RST_BIST     = 1'h0;

  typedef enum logic [1:0] {
    SPIC_MODE_CURRENT,
    SPIC_MODE_CURRENT_FILT,
    SPIC_MODE_LEGACY_A,
    SPIC_MODE_LEGACY_B
  } spic_mode_t;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] data;
    logic                  data_enable;
    logic                  hsync;
    logic                  vsync;
  } spic_word_t;

  typedef struct packed {
    logic       pclk;
    logic       pdn;
    logic       swing;
    logic       edge_sel;
    logic [1:0] compat;
    logic       bist;
    spic_word_t word;
  } spic_pins_t;

  typedef struct packed {
    logic       swing_large;
    logic       edge_rising;
    spic_mode_t mode;
    logic       bist;
  } spic_cfg_t;

endpackage

// [core/spic_filter.sv]
// Minimum-width glitch filter for one control signal
`timescale 1ns/100ps
`default_nettype none
module spic_filter #(
  parameter int COUNT = spic_pkg::FILTER_COUNT
) (
  input  wire logic ref_clk,     // System clock
  input  wire logic sys_rst,     // Synchronous reset, active high
  input  wire logic clear,       // Return to low level
  input  wire logic enable,      // Filter active
  input  wire logic sample_stb,  // One sample per capture edge
  input  wire logic raw,         // Sampled control level
  output logic      filtered     // Forwarded level
);

  if (COUNT < 2 || COUNT > 15) begin
    $error("spic_filter: COUNT out of range");
  end

  typedef struct packed {
    logic       lvl;
    logic [3:0] cnt;
  } spic_filt_state_t;

  spic_filt_state_t st_reg;
  spic_filt_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next = '0;
    end else if (sample_stb) begin
      if (!enable) begin
        st_next.lvl = raw;
        st_next.cnt = 4'h0;
      end else if (raw == st_reg.lvl) begin
        st_next.cnt = 4'h0;
      end else if (st_reg.cnt == 4'(COUNT - 1)) begin
        st_next.lvl = raw;
        st_next.cnt = 4'h0;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filtered = st_reg.lvl;

endmodule
`default_nettype wire

// [core/spic_top.sv]
// Parallel pixel capture, control filter and pin-level configuration
// How it works
// - Code 01: forward DE/HSYNC change only after three stable samples.
// - Code 00: control changes pass through with no minimum width.
// - Edge select 1 samples the pixel data, DE and sync inputs on pixel clock rising edge unless edge_override_en is set.
// - Edge select 0 samples the pixel data, DE and sync inputs on pixel clock falling edge unless edge_override_en is set.
// - Power-down input high: normal capture and serial drive.
// - Power-down input low: both serial legs high, clock multiplier stopped.
// - Entering power-down returns all control settings to reset values.
// - Swing select 1 picks large swing, 0 small; override port possible.
// - Codes 10 and 11 pick two distinct legacy far-end modes.
// - Self-test enable 1 enters self-test, 0 normal operation.
// - Data enable uses same filter and rate limits as HSYNC.
`timescale 1ns/100ps
`default_nettype none
module spic_top #(
  parameter int DATA_WIDTH = spic_pkg::DATA_WIDTH
) (
  input  wire logic                  ref_clk,          // 40 MHz system clock
  input  wire logic                  sys_rst,          // Synchronous reset, active high
  input  wire logic                  pixel_clock_in,   // Pixel clock pin
  input  wire logic [DATA_WIDTH-1:0] pixel_data_in,    // Pixel data pins
  input  wire logic                  data_enable_in,   // Data enable pin
  input  wire logic                  hsync_in,         // Horizontal sync pin
  input  wire logic                  vsync_in,         // Vertical sync pin
  input  wire logic                  power_down_n,     // Low powers the block down
  input  wire logic                  swing_select,     // Output swing pin
  input  wire logic                  capture_edge_select, // 1 rising, 0 falling
  input  wire logic [1:0]            compat_select,    // Filter / legacy mode pins
  input  wire logic                  self_test_enable, // Self-test pin
  input  wire logic                  edge_override_en, // Use edge_override_val
  input  wire logic                  edge_override_val,// Overriding edge choice
  input  wire logic                  swing_override_en,// Use swing_override_val
  input  wire logic                  swing_override_val,// Overriding swing choice
  output spic_pkg::spic_word_t       out_word,         // Captured word
  output logic                       out_valid,        // Word available
  input  wire logic                  out_ready,        // Receiver takes word
  output logic                       capture_ready,    // Buffer has room
  output logic                       capture_overflow, // Word lost, sticky until reset
  output logic                       serial_hold_high, // Both serial legs forced high
  output logic                       pll_run,          // Clock multiplier enabled
  output logic                       swing_large,      // Large output swing chosen
  output spic_pkg::spic_mode_t       link_mode,        // Far-end compatibility mode
  output logic                       filter_active,    // Control filter on
  output logic                       self_test_active  // Self-test running
);

  if (DATA_WIDTH != spic_pkg::DATA_WIDTH) begin
    $error("spic_top: DATA_WIDTH must be 24");
  end

  typedef struct packed {
    spic_pkg::spic_pins_t                         s1;
    spic_pkg::spic_pins_t                         s2;
    spic_pkg::spic_pins_t                         s3;
    logic                                         pclk_lvl;
    logic                                         pdn_lvl;
    spic_pkg::spic_cfg_t                          cfg;
    spic_pkg::spic_word_t [spic_pkg::BUF_DEPTH-1:0] buf_mem;
    logic [1:0]                                   count;
    logic [DATA_WIDTH-1:0]                        pattern;
    logic                                         overflow;
    logic                                         push_pending;
    logic [DATA_WIDTH-1:0]                        data_hold;
    logic                                         vs_hold;
  } spic_state_t;

  spic_state_t          st_reg;
  spic_state_t          st_next;
  spic_pkg::spic_pins_t pins;
  logic                 edge_hit;
  logic                 de_filt;
  logic                 hs_filt;
  logic                 pd_now;

  function automatic spic_pkg::spic_mode_t decode_mode(input logic [1:0] code);
    spic_pkg::spic_mode_t m;
    m = spic_pkg::SPIC_MODE_CURRENT;
    if (code == spic_pkg::CFG_FILT_ON) begin
      m = spic_pkg::SPIC_MODE_CURRENT_FILT;
    end else if (code == spic_pkg::CFG_LEGACY_A) begin
      m = spic_pkg::SPIC_MODE_LEGACY_A;
    end else if (code == spic_pkg::CFG_LEGACY_B) begin
      m = spic_pkg::SPIC_MODE_LEGACY_B;
    end
    return m;
  endfunction

  always_comb begin
    pins.pclk        = pixel_clock_in;
    pins.pdn         = power_down_n;
    pins.swing       = swing_select;
    pins.edge_sel    = capture_edge_select;
    pins.compat      = compat_select;
    pins.bist        = self_test_enable;
    pins.word.data   = pixel_data_in;
    pins.word.data_enable = data_enable_in;
    pins.word.hsync  = hsync_in;
    pins.word.vsync  = vsync_in;
  end

  // Power-down seen as the agreed level of the last two stages
  assign pd_now = !st_reg.pdn_lvl;

  assign edge_hit = (st_reg.s2.pclk == st_reg.s3.pclk) && (st_reg.s3.pclk != st_reg.pclk_lvl) &&
                    (st_reg.s3.pclk == st_reg.cfg.edge_rising) && !pd_now;

  assign capture_ready = (st_reg.count < 2'(spic_pkg::BUF_DEPTH));

  // filter on only for code 01
  spic_filter #(
    .COUNT (spic_pkg::FILTER_COUNT)
  ) u_filt_de (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .clear      (pd_now),
    .enable     (st_reg.cfg.mode == spic_pkg::SPIC_MODE_CURRENT_FILT),
    .sample_stb (edge_hit),
    .raw        (st_reg.s3.word.data_enable),
    .filtered   (de_filt)
  );

  spic_filter #(
    .COUNT (spic_pkg::FILTER_COUNT)
  ) u_filt_hs (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .clear      (pd_now),
    .enable     (st_reg.cfg.mode == spic_pkg::SPIC_MODE_CURRENT_FILT),
    .sample_stb (edge_hit),
    .raw        (st_reg.s3.word.hsync),
    .filtered   (hs_filt)
  );

  // Filtered levels settle one cycle after the edge; the word is pushed then
  spic_pkg::spic_word_t push_word;
  logic                 push;
  logic                 pop;

  always_comb begin
    push_word.data        = st_reg.data_hold;
    push_word.data_enable = de_filt;
    push_word.hsync       = hs_filt;
    push_word.vsync       = st_reg.vs_hold;
  end

  assign pop  = out_valid && out_ready;
  assign push = st_reg.push_pending && !pd_now;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.push_pending = edge_hit;
    st_next.data_hold    = st_reg.cfg.bist ? st_reg.pattern : st_reg.s3.word.data;
    st_next.vs_hold      = st_reg.s3.word.vsync;
    if (st_reg.s2.pclk == st_reg.s3.pclk) begin
      st_next.pclk_lvl = st_reg.s3.pclk;
    end
    if (st_reg.s2.pdn == st_reg.s3.pdn) begin
      st_next.pdn_lvl = st_reg.s3.pdn;
    end
    if (pd_now) begin
      st_next.cfg.swing_large = spic_pkg::RST_SWING;
      st_next.cfg.edge_rising = spic_pkg::RST_RISING;
      st_next.cfg.mode        = spic_pkg::SPIC_MODE_CURRENT;
      st_next.cfg.bist        = spic_pkg::RST_BIST;
      st_next.count           = 2'h0;
      st_next.pattern         = '0;
    end else begin
      if (st_reg.s2.edge_sel == st_reg.s3.edge_sel) begin
        st_next.cfg.edge_rising = edge_override_en ? edge_override_val : st_reg.s3.edge_sel;
      end
      if (st_reg.s2.swing == st_reg.s3.swing) begin
        st_next.cfg.swing_large = swing_override_en ? swing_override_val : st_reg.s3.swing;
      end
      if (st_reg.s2.compat == st_reg.s3.compat) begin
        st_next.cfg.mode = decode_mode(st_reg.s3.compat);
      end
      if (st_reg.s2.bist == st_reg.s3.bist) begin
        st_next.cfg.bist = st_reg.s3.bist;
      end
      if (edge_hit && st_reg.cfg.bist) begin
        st_next.pattern = st_reg.pattern + DATA_WIDTH'(1);
      end
      if (pop) begin
        st_next.buf_mem[0] = st_reg.buf_mem[1];
      end
      if (push && (capture_ready || pop)) begin
        st_next.buf_mem[(pop ? st_reg.count - 2'h1 : st_reg.count) == 2'h0 ? 0 : 1] = push_word;
      end
      if (push && !capture_ready && !pop) begin
        st_next.overflow = 1'h1;
      end
      st_next.count = st_reg.count + 2'((push && (capture_ready || pop)) ? 1 : 0) - 2'(pop ? 1 : 0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_word         = st_reg.buf_mem[0];
  assign out_valid        = (st_reg.count != 2'h0);
  assign capture_overflow = st_reg.overflow;
  assign serial_hold_high = pd_now;
  assign pll_run          = !pd_now;
  assign swing_large      = st_reg.cfg.swing_large;
  assign link_mode        = st_reg.cfg.mode;
  assign filter_active    = (st_reg.cfg.mode == spic_pkg::SPIC_MODE_CURRENT_FILT);
  assign self_test_active = st_reg.cfg.bist;

endmodule
`default_nettype wire

// [tb/spic_top_asserts.sv]
// Port-level assertions for the parallel input control block
`timescale 1ns/100ps
`default_nettype none
module spic_top_asserts #(
  parameter int DATA_WIDTH = spic_pkg::DATA_WIDTH
) (
  input wire logic                 ref_clk,            // System clock
  input wire logic                 sys_rst,            // Synchronous reset
  input wire logic                 power_down_n,       // Power-down pin
  input wire logic                 swing_select,       // Swing pin
  input wire logic [1:0]           compat_select,      // Mode pins
  input wire logic                 self_test_enable,   // Self-test pin
  input wire logic                 swing_override_en,  // Swing override on
  input wire logic                 swing_override_val, // Swing override value
  input wire spic_pkg::spic_word_t out_word,           // Captured word
  input wire logic                 out_valid,          // Word available
  input wire logic                 out_ready,          // Receiver ready
  input wire logic                 capture_ready,      // Buffer room
  input wire logic                 serial_hold_high,   // Legs held high
  input wire logic                 pll_run,            // Multiplier on
  input wire logic                 swing_large,        // Large swing
  input wire spic_pkg::spic_mode_t link_mode,          // Far-end mode
  input wire logic                 filter_active,      // Filter on
  input wire logic                 self_test_active    // Self-test on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Powered up with the mode, swing, swing override and self-test pins unchanged long enough to pass sync
  sequence pins_quiet;
    (!serial_hold_high && $stable(compat_select) && $stable(swing_select) && $stable(self_test_enable)
      && $stable(swing_override_en) && $stable(swing_override_val))[*6];
  endsequence
  sequence powered_off;
    !power_down_n[*6];
  endsequence

  AST_PLL_PAIR: assert property (pll_run != serial_hold_high)
    else $error("pll_run not inverse of serial_hold_high");
  AST_PD_HOLD: assert property (powered_off |-> serial_hold_high)
    else $error("serial legs not held high in power-down");
  AST_PD_CLEAR: assert property (serial_hold_high[*2] |-> !out_valid && capture_ready
    && swing_large == spic_pkg::RST_SWING && self_test_active == spic_pkg::RST_BIST
    && link_mode == spic_pkg::SPIC_MODE_CURRENT)
    else $error("settings not at reset values in power-down");
  AST_MODE: assert property (pins_quiet |-> link_mode == spic_pkg::spic_mode_t'(compat_select))
    else $error("link_mode does not follow compat_select");
  AST_FILT: assert property (pins_quiet |-> filter_active == (compat_select == spic_pkg::CFG_FILT_ON))
    else $error("filter_active does not follow compat_select");
  AST_SWING: assert property (pins_quiet
    |-> swing_large == (swing_override_en ? swing_override_val : swing_select))
    else $error("swing_large does not follow swing choice");
  AST_BIST: assert property (pins_quiet |-> self_test_active == self_test_enable)
    else $error("self_test_active does not follow pin");
  AST_HOLD_WORD: assert property (out_valid && !out_ready && power_down_n
    |=> serial_hold_high || (out_valid && $stable(out_word)))
    else $error("stalled word lost or changed");
  AST_FULL: assert property (!capture_ready |-> out_valid)
    else $error("buffer full without a valid word");
endmodule
bind spic_top spic_top_asserts #(.DATA_WIDTH(DATA_WIDTH)) u_asserts (
  .ref_clk, .sys_rst, .power_down_n, .swing_select, .compat_select, .self_test_enable,
  .swing_override_en, .swing_override_val, .out_word, .out_valid, .out_ready, .capture_ready,
  .serial_hold_high, .pll_run, .swing_large, .link_mode, .filter_active, .self_test_active
);
`default_nettype wire

// [tb/spic_host.sv]
// Host video source model driving the parallel pixel pins
`timescale 1ns/100ps
`default_nettype none
module spic_host (
  input  wire logic                            ref_clk,        // System clock
  output logic                                 pixel_clock_in, // Pixel clock pin
  output logic [spic_pkg::DATA_WIDTH-1:0]      pixel_data_in,  // Pixel data pins
  output logic                                 data_enable_in, // Data enable pin
  output logic                                 hsync_in,       // Horizontal sync pin
  output logic                                 vsync_in        // Vertical sync pin
);
  initial {pixel_clock_in, pixel_data_in, data_enable_in, hsync_in, vsync_in} = '0;

  // inverted data around the non-capturing edge
  task automatic send(input spic_pkg::spic_word_t w, input logic edge_lvl);
    pixel_clock_in = !edge_lvl;
    pixel_data_in = ~w.data;
    repeat (4) @(negedge ref_clk);
    {pixel_data_in, data_enable_in, hsync_in, vsync_in} = w;
    repeat (2) @(negedge ref_clk);
    pixel_clock_in = edge_lvl;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the parallel input control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, sys_rst = 1'b1, power_down_n = 1'b1, swing_select = 1'b0;
  logic capture_edge_select = 1'b1, self_test_enable = 1'b0, edge_override_en = 1'b0;
  logic edge_override_val = 1'b0, swing_override_en = 1'b0, swing_override_val = 1'b0;
  logic out_ready = 1'b0, stall = 1'b0, filt_on = 1'b0, edge_eff = 1'b1, fde = 1'b0, fhs = 1'b0;
  logic [1:0] compat_select = 2'h0;
  wire logic pixel_clock_in, data_enable_in, hsync_in, vsync_in;
  wire logic [spic_pkg::DATA_WIDTH-1:0] pixel_data_in;
  spic_pkg::spic_word_t out_word, q[$];
  spic_pkg::spic_mode_t link_mode;
  logic out_valid, capture_ready, capture_overflow, serial_hold_high, pll_run, swing_large;
  logic filter_active, self_test_active;
  int seed = 31, n_errors = 0, check_count = 0, cde = 0, chs = 0, bist_n = 0;

  spic_top dut (
    .ref_clk, .sys_rst, .pixel_clock_in, .pixel_data_in, .data_enable_in, .hsync_in, .vsync_in,
    .power_down_n, .swing_select, .capture_edge_select, .compat_select, .self_test_enable,
    .edge_override_en, .edge_override_val, .swing_override_en, .swing_override_val, .out_word,
    .out_valid, .out_ready, .capture_ready, .capture_overflow, .serial_hold_high, .pll_run,
    .swing_large, .link_mode, .filter_active, .self_test_active
  );
  spic_host host (.ref_clk, .pixel_clock_in, .pixel_data_in, .data_enable_in, .hsync_in, .vsync_in);

  task automatic chk_word(input string what, input spic_pkg::spic_word_t exp, input spic_pkg::spic_word_t got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Expected forwarded control level after one capture
  function automatic void filt(input logic raw, inout logic lvl, inout int cnt);
    cnt = (raw == lvl) ? 0 : cnt + 1;
    if (!filt_on || cnt == spic_pkg::FILTER_COUNT) begin
      lvl = raw;
      cnt = 0;
    end
  endfunction
  task automatic put(input spic_pkg::spic_word_t w);
    spic_pkg::spic_word_t e;
    e = w;
    // Self-test words carry the capture count since power-up
    if (self_test_enable) begin
      e.data = 24'(bist_n);
      bist_n++;
    end
    filt(w.data_enable, fde, cde);
    filt(w.hsync, fhs, chs);
    e.data_enable = fde;
    e.hsync = fhs;
    q.push_back(e);
    host.send(w, edge_eff);
  endtask
  task automatic drain();
    for (int i = 0; i < 100 && q.size() > 0; i++) @(negedge ref_clk);
    chk_pin("words_left", 2'h0, 2'(q.size()));
  endtask
  task automatic round(input int r);
    spic_pkg::spic_word_t w;
    compat_select = 2'(r);
    filt_on = compat_select == spic_pkg::CFG_FILT_ON;
    {capture_edge_select, edge_override_en, edge_override_val} = 3'($random(seed));
    {swing_select, swing_override_en, swing_override_val} = 3'($random(seed));
    edge_eff = edge_override_en ? edge_override_val : capture_edge_select;
    repeat (8) @(negedge ref_clk);
    chk_pin("link_mode", compat_select, link_mode);
    chk_pin("filter_active", filt_on, filter_active);
    chk_pin("swing_large", swing_override_en ? swing_override_val : swing_select, swing_large);
    chk_pin("self_test_active", 1'b0, self_test_active);
    // one pulse of 1 to 3 clocks, then steady clocks, 133 clocks in all
    for (int i = 0; i < 133; i++) begin
      w.data = 24'($random(seed));
      w.data_enable = i < r / 4 + 1;
      w.hsync = i < 3 - r / 4;
      w.vsync = r[0];
      put(w);
    end
  endtask

  initial forever #12.5 ref_clk = ~ref_clk;
  // Word is checked while it stands, before the edge that pops it
  always @(negedge ref_clk) begin
    logic rdy;
    rdy = stall ? 1'b0 : 1'($random(seed));
    out_ready <= rdy;
    if (out_valid === 1'b1 && rdy)
      chk_word("out_word", q.size() > 0 ? q.pop_front() : 'x, out_word);
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int r = 0; r < 12; r++) round(r);
    drain();
    swing_select = 1'b1;
    swing_override_en = 1'b0;
    self_test_enable = 1'b1;
    power_down_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk_pin("serial_hold_high", 1'b1, serial_hold_high);
    chk_pin("pll_run", 1'b0, pll_run);
    chk_pin("swing_large", spic_pkg::RST_SWING, swing_large);
    chk_pin("link_mode", spic_pkg::SPIC_MODE_CURRENT, link_mode);
    chk_pin("self_test_active", spic_pkg::RST_BIST, self_test_active);
    host.send(27'h1, 1'b0);
    chk_pin("out_valid", 1'b0, out_valid);
    power_down_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_pin("serial_hold_high", 1'b0, serial_hold_high);
    chk_pin("self_test_active", 1'b1, self_test_active);
    repeat (3) put({24'($random(seed)), 3'h1});
    self_test_enable = 1'b0;
    round(1);
    drain();
    chk_pin("capture_overflow", 1'b0, capture_overflow);
    stall = 1'b1;
    repeat (3) put({24'($random(seed)), 3'h0});
    repeat (8) @(negedge ref_clk);
    chk_pin("capture_ready", 1'b0, capture_ready);
    chk_pin("capture_overflow", 1'b1, capture_overflow);
    void'(q.pop_back());
    stall = 1'b0;
    drain();
    summarize();
  end

  initial begin
    #(60000 * 25);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
